// ===== logic/uart_rx_status.sv
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module uart_rx_status
  import uart_rx_status_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // serial line
  input  wire logic        rxd
);
  import uart_rx_status_pkg::*;

  // receiver state
  rx_state_e   state_reg,   state_next;     // frame sequencer
  logic [15:0] timer_reg,   timer_next;     // clocks to next sample
  logic [3:0]  bits_reg,    bits_next;      // data bits taken
  logic [8:0]  shift_reg,   shift_next;     // receive shift register
  logic        par_reg,     par_next;       // running parity
  logic        parity_error_flag_reg,    parity_error_flag_next;      // parity verdict
  logic        done;                        // character complete pulse
  logic        done_framing_error_flag;                   // stop bit sampled low
  // bus and buffer state
  logic [7:0]  waddr_reg,   waddr_next;     // write data phase address
  logic        wpend_reg,   wpend_next;     // write data phase pending
  logic [31:0] rdata_reg,   rdata_next;     // read answer
  logic        address_detect_enable_reg,   address_detect_enable_next;     // address detect enable
  logic [2:0]  mode_reg,    mode_next;      // nine-bit, parity enable, odd
  logic [15:0] div_reg,     div_next;       // clocks per bit minus one
  logic        overrun_error_flag_reg,    overrun_error_flag_next;      // overrun flag
  logic [1:0]  wptr_reg,    wptr_next;      // fifo write pointer
  logic [1:0]  rptr_reg,    rptr_next;      // fifo read pointer
  logic [2:0]  count_reg,   count_next;     // fifo fill
  logic [entry_w-1:0] mem [fifo_depth];     // fifo storage
  // decoded events
  logic        rd_req;                      // read address phase taken
  logic        pop;                         // read of rx data pops head
  logic        clr_ovr;                     // overrun cleared by software
  logic        keep;                        // character passes address filter
  logic        push;                        // character stored
  logic        nine;                        // nine-bit mode
  logic [entry_w-1:0] head;                 // head entry or zero
  logic [15:0] status;                      // status register image

  assign nine      = mode_reg[nine_bit_pos];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // address phase decode
  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    hit = (a[31:8] == 24'h000000) && (a[7:0] == off);
  endfunction

  assign rd_req  = hsel && hready && htrans[1] && !hwrite;
  assign pop     = rd_req && hit(haddr, rx_data_off) && (count_reg != 3'h0);
  // clearing a set overrun flag by writing zero
  assign clr_ovr = wpend_reg && (waddr_reg == status_off) && !hwdata[overrun_bit]
                   && overrun_error_flag_reg;
  // address characters only, and only when nine-bit framing is on
  assign keep    = !(address_detect_enable_reg && nine) || shift_reg[8];
  // overrun drops characters and leaves the buffer alone
  assign push    = done && keep && !overrun_error_flag_reg && !clr_ovr
                   && ((count_reg != fifo_full) || pop);
  assign head    = (count_reg != 3'h0) ? mem[rptr_reg] : '0;
  assign status  = {10'h0, address_detect_enable_reg, (state_reg == rx_idle),
                    head[data_parity_error_flag_pos], head[data_framing_error_flag_pos],
                    overrun_error_flag_reg, (count_reg != 3'h0)};

  // receiver next state: start check at mid bit, then full bit periods
  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    bits_next  = bits_reg;
    shift_next = shift_reg;
    par_next   = par_reg;
    parity_error_flag_next  = parity_error_flag_reg;
    done       = 1'b0;
    done_framing_error_flag  = 1'b0;
    if (timer_reg != 16'h0000)
      timer_next = timer_reg - 16'h0001;
    case (state_reg)
      rx_idle:
        if (!rxd)
        begin
          state_next = rx_start;
          timer_next = {1'b0, div_reg[15:1]};
        end
      rx_start:
        if (timer_reg == 16'h0000)
        begin
          // a short low pulse is noise, not a start bit
          state_next = rxd ? rx_idle : rx_data;
          timer_next = div_reg;
          bits_next  = 4'h0;
          shift_next = 9'h000;
          par_next   = mode_reg[parity_odd_pos];
          parity_error_flag_next  = 1'b0;
        end
      rx_data:
        if (timer_reg == 16'h0000)
        begin
          timer_next = div_reg;
          shift_next = nine ? {rxd, shift_reg[8:1]} : {1'b0, rxd, shift_reg[7:1]};
          par_next   = par_reg ^ rxd;
          bits_next  = bits_reg + 4'h1;
          if (bits_reg == (nine ? 4'h8 : 4'h7))
            state_next = (mode_reg[parity_en_pos] && !nine) ? rx_parity : rx_stop;
        end
      rx_parity:
        if (timer_reg == 16'h0000)
        begin
          timer_next = div_reg;
          parity_error_flag_next  = par_reg ^ rxd;
          state_next = rx_stop;
        end
      rx_stop:
        if (timer_reg == 16'h0000)
        begin
          done       = 1'b1;
          done_framing_error_flag  = !rxd;
          state_next = rx_idle;
        end
      default:
        state_next = rx_idle;
    endcase
    // emptying the shifter abandons any character in flight
    if (clr_ovr)
    begin
      state_next = rx_idle;
      shift_next = 9'h000;
    end
  end

  // receiver registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= rx_idle;
      timer_reg <= 16'h0000;
      bits_reg  <= 4'h0;
      shift_reg <= 9'h000;
      par_reg   <= 1'b0;
      parity_error_flag_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      bits_reg  <= bits_next;
      shift_reg <= shift_next;
      par_reg   <= par_next;
      parity_error_flag_reg  <= parity_error_flag_next;
    end
  end

  // bus, control and buffer next state
  always_comb
  begin
    waddr_next = waddr_reg;
    wpend_next = 1'b0;
    rdata_next = rdata_reg;
    address_detect_enable_next = address_detect_enable_reg;
    mode_next  = mode_reg;
    div_next   = div_reg;
    overrun_error_flag_next  = overrun_error_flag_reg;
    wptr_next  = wptr_reg;
    rptr_next  = rptr_reg;
    count_next = count_reg;
    // take address phases, capture write targets
    if (hsel && hready && htrans[1] && hwrite)
    begin
      wpend_next = 1'b1;
      waddr_next = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
    end
    // read answer is fixed in the address phase
    if (rd_req)
    begin
      if (hit(haddr, status_off))
        rdata_next = {16'h0000, status};
      else if (hit(haddr, mode_off))
        rdata_next = {29'h0, mode_reg};
      else if (hit(haddr, divisor_off))
        rdata_next = {16'h0000, div_reg};
      else if (hit(haddr, rx_data_off))
        rdata_next = {21'h0, head};
      else
        rdata_next = 32'h00000000;
    end
    // register writes in the data phase
    if (wpend_reg)
    begin
      case (waddr_reg)
        status_off:  address_detect_enable_next = hwdata[addr_detect_bit];
        mode_off:    mode_next  = hwdata[2:0];
        divisor_off: div_next   = hwdata[15:0];
        default:     div_next   = div_reg;
      endcase
    end
    // fifo bookkeeping
    if (push)
      wptr_next = wptr_reg + 2'h1;
    if (pop)
      rptr_next = rptr_reg + 2'h1;
    count_next = count_reg + {2'h0, push} - {2'h0, pop};
    // overflow sets, software zero clears and flushes
    if (done && keep && !overrun_error_flag_reg && (count_reg == fifo_full) && !pop)
      overrun_error_flag_next = 1'b1;
    else if (clr_ovr)
    begin
      overrun_error_flag_next  = 1'b0;
      wptr_next  = 2'h0;
      rptr_next  = 2'h0;
      count_next = 3'h0;
    end
  end

  // bus, control and buffer registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      waddr_reg <= 8'h00;
      wpend_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      address_detect_enable_reg <= 1'b0;
      mode_reg  <= mode_rst;
      div_reg   <= divisor_rst;
      overrun_error_flag_reg  <= 1'b0;
      wptr_reg  <= 2'h0;
      rptr_reg  <= 2'h0;
      count_reg <= 3'h0;
    end
    else
    begin
      waddr_reg <= waddr_next;
      wpend_reg <= wpend_next;
      rdata_reg <= rdata_next;
      address_detect_enable_reg <= address_detect_enable_next;
      mode_reg  <= mode_next;
      div_reg   <= div_next;
      overrun_error_flag_reg  <= overrun_error_flag_next;
      wptr_reg  <= wptr_next;
      rptr_reg  <= rptr_next;
      count_reg <= count_next;
    end
  end

  // fifo storage, entry carries its own error verdicts
  always_ff @(posedge hclk)
  begin
    if (push)
      mem[wptr_reg] <= {done_framing_error_flag, parity_error_flag_reg, shift_reg};
  end

  // checks
  sequence s_clear_write;
    wpend_reg && (waddr_reg == status_off) && !hwdata[overrun_bit] && overrun_error_flag_reg;
  endsequence

  sequence s_overflow;
    done && keep && !overrun_error_flag_reg && (count_reg == fifo_full) && !pop;
  endsequence

  a_addr_filter_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    done && address_detect_enable_reg && nine && !shift_reg[8] && !clr_ovr |=> $stable(wptr_reg))
    else $error("non-address character stored in address detect mode");

  a_eight_bit_pass: assert property (@(posedge hclk) disable iff (!hresetn)
    done && address_detect_enable_reg && !nine && !overrun_error_flag_reg && (count_reg < fifo_full) && !pop
    |=> count_reg == $past(count_reg) + 3'h1)
    else $error("address filter acted outside nine-bit mode");

  a_idle_flag_state: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(rxd) && (state_reg == rx_idle) && !clr_ovr |=> !status[idle_bit])
    else $error("idle flag high after start edge");

  a_head_parity: assert property (@(posedge hclk) disable iff (!hresetn)
    status[parity_err_bit] |-> (count_reg != 3'h0) && mem[rptr_reg][data_parity_error_flag_pos])
    else $error("parity flag not from head entry");

  a_head_framing: assert property (@(posedge hclk) disable iff (!hresetn)
    push && (count_reg == 3'h0) && done_framing_error_flag |=> status[framing_err_bit])
    else $error("framing flag missing for head character");

  a_overrun_sets: assert property (@(posedge hclk) disable iff (!hresetn)
    s_overflow |=> overrun_error_flag_reg ##1 (overrun_error_flag_reg || $past(clr_ovr)))
    else $error("overrun flag not set on overflow");

  a_overrun_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    overrun_error_flag_reg && !clr_ovr |=> overrun_error_flag_reg)
    else $error("overrun flag cleared without software");

  a_clear_flushes: assert property (@(posedge hclk) disable iff (!hresetn)
    s_clear_write |=> (count_reg == 3'h0) && (state_reg == rx_idle) && !overrun_error_flag_reg)
    else $error("overrun clear did not empty receiver");

  a_avail_on_push: assert property (@(posedge hclk) disable iff (!hresetn)
    push && !pop |=> status[avail_bit] && (count_reg == $past(count_reg) + 3'h1))
    else $error("data available not raised after store");

  a_overrun_discard: assert property (@(posedge hclk) disable iff (!hresetn)
    overrun_error_flag_reg && done && !clr_ovr |=> $stable(wptr_reg))
    else $error("character stored while overrun set");
endmodule

// ===== logic/uart_rx_status_pkg.sv
// What this block does
// - address enable keeps only ninth-bit-set characters
// - address filter acts only in 9-bit mode
// - idle flag reads 1 unless receiving
// - parity flag belongs to head character
// - framing flag belongs to head character
// - overrun sets on overflow, software clears
// - clearing overrun empties buffer and shifter
// - data available while buffer holds characters
package uart_rx_status_pkg;
  // byte offsets of the word registers
  localparam logic [7:0] status_off      = 8'h00;   // status and control
  localparam logic [7:0] mode_off        = 8'h04;   // frame format
  localparam logic [7:0] divisor_off     = 8'h08;   // clocks per bit minus one
  localparam logic [7:0] rx_data_off     = 8'h0C;   // received character, read pops
  // status field positions
  localparam int addr_detect_bit  = 5;
  localparam int idle_bit         = 4;
  localparam int parity_err_bit   = 3;
  localparam int framing_err_bit  = 2;
  localparam int overrun_bit      = 1;
  localparam int avail_bit        = 0;
  // mode field positions
  localparam int nine_bit_pos     = 0;
  localparam int parity_en_pos    = 1;
  localparam int parity_odd_pos   = 2;
  // rx data field positions
  localparam int data_parity_error_flag_pos    = 9;
  localparam int data_framing_error_flag_pos    = 10;
  // reset values
  localparam logic [15:0] divisor_rst = 16'h0010;
  localparam logic [2:0]  mode_rst    = 3'h0;
  // receive fifo
  localparam int          fifo_depth  = 4;
  localparam logic [2:0]  fifo_full   = 3'h4;
  localparam int          entry_w     = 11;      // 9 data bits, parity_error_flag, framing_error_flag
  // receiver states, one-hot
  typedef enum logic [4:0]
  {
    rx_idle   = 5'b00001,
    rx_start  = 5'b00010,
    rx_data   = 5'b00100,
    rx_parity = 5'b01000,
    rx_stop   = 5'b10000
  } rx_state_e;
endpackage

// ===== sim/uart_rx_status_tb.sv
`timescale 1ns/1ps
module uart_rx_status_tb;
  import uart_rx_status_pkg::*;
  // bus and line signals
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rxd;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  // reference model state
  int          mismatches, checks, cyc, seed, d;
  int          q[$];
  bit          ovr, address_detect_enable, nine, paren, odd;
  // single slave, so its ready is the bus ready
  assign hready = hreadyout;
  uart_rx_status uart_rx_status_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd));
  uart_tx_model uart_tx_model_inst (.hclk(hclk), .rxd(rxd));
  // 100 mhz clock
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      mismatches++;
      $display("CHECK FAILED %0t timeout", $time);
      complete_run();
    end
  end
  // verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // compare one register word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one single ahb-lite transfer, read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'h2; hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response");
  endtask
  // expected status word from the model
  function automatic logic [31:0] st_exp();
    int h = q.size() ? q[0] : 0;
    return {26'h0, address_detect_enable, 1'b1, h[9], h[10], ovr, q.size() != 0};
  endfunction
  // read status and compare
  task automatic st();
    bus(1'b0, status_off, 32'h0);
    chk(rd, st_exp(), "status");
  endtask
  // frame format and address detect setup
  task automatic cfg(input bit n, input bit p, input bit o, input bit a);
    nine = n; paren = p; odd = o; address_detect_enable = a;
    // the status write carries a zero overrun bit, which clears and flushes
    if (ovr) q.delete();
    ovr = 0;
    bus(1'b1, mode_off, {29'h0, o, p, n});
    bus(1'b1, status_off, {26'h0, a, 5'h0});
  endtask
  // send a frame and let the model take it the way the receiver should
  task automatic rx(input int data, input int par, input int stop);
    int e;
    e = data | ((stop == 0) << 10);
    if (paren && !nine && par != ((^data[7:0]) ^ odd)) e = e | 32'h200;
    // the receiver counts divisor plus one clocks per bit, divisor is 4
    uart_tx_model_inst.send(data, nine ? 9 : 8, (paren && !nine) ? par : -1, stop, 5);
    repeat (3) @(posedge hclk);
    if (ovr) return;
    if (address_detect_enable && nine && !data[8]) return;
    if (q.size() == fifo_depth) ovr = 1;
    else q.push_back(e);
  endtask
  // read the head character and compare
  task automatic pop();
    bus(1'b0, rx_data_off, 32'h0);
    chk(rd, q[0], "data");
    void'(q.pop_front());
    st();
  endtask
  initial
  begin
    seed = 32'hC74F818C;
    hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    st();
    bus(1'b0, divisor_off, 32'h0);
    chk(rd, {16'h0, divisor_rst}, "divisor reset");
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0, "unmapped");
    bus(1'b1, divisor_off, 32'h4);
    // even and odd parity, good and bad, then a framing fault
    for (int i = 0; i < 4; i++)
    begin
      cfg(0, 1, i[1], 0);
      d = $random(seed) & 255;
      rx(d, (^d[7:0]) ^ i[1] ^ i[0], 1);
      st();
      pop();
    end
    rx($random(seed) & 255, 0, 0);
    st();
    while (q.size() > 0) pop();
    // idle flag drops during a frame
    cfg(0, 0, 0, 0);
    fork
      rx($random(seed) & 255, 0, 1);
      begin
        repeat (12) @(posedge hclk);
        bus(1'b0, status_off, 32'h0);
        chk({31'h0, rd[idle_bit]}, 32'h0, "busy idle");
      end
    join
    pop();
    // overflow, dropped characters, clear
    for (int i = 0; i < 6; i++) rx($random(seed) & 255, 0, 1);
    st();
    pop();
    bus(1'b1, status_off, 32'h2);
    st();
    bus(1'b1, status_off, 32'h0);
    ovr = 0;
    q.delete();
    st();
    rx($random(seed) & 255, 0, 1);
    pop();
    // address detect in 9-bit and in 8-bit mode
    cfg(1, 0, 0, 1);
    rx($random(seed) & 255, 0, 1);
    rx(($random(seed) & 255) | 256, 0, 1);
    st();
    pop();
    cfg(0, 0, 0, 1);
    rx($random(seed) & 255, 0, 1);
    pop();
    complete_run();
  end
endmodule

// ===== sim/uart_tx_model.sv
`timescale 1ns/1ps
module uart_tx_model
(
  // clock
  input  wire logic hclk,
  // serial line to the receiver
  output logic      rxd
);
  // line rests at mark level between frames
  initial rxd = 1'b1;
  // one frame, start bit then lsb first; par below zero means no parity bit
  task automatic send(input int data, input int nb, input int par, input int stop,
                      input int div);
    int bits[$];
    bits = {0};
    for (int i = 0; i < nb; i++) bits.push_back((data >> i) & 1);
    if (par >= 0) bits.push_back(par);
    bits.push_back(stop);
    foreach (bits[k]) repeat (div) @(posedge hclk) rxd <= bits[k][0];
    @(posedge hclk) rxd <= 1'b1;
  endtask
endmodule
